// ### common/adc_ctrl_pkg.sv
/*
 * constants, field positions and types of the converter control block.
 * assumes one 125 MHz register clock and byte-addressed 32-bit registers.
 */
package adc_ctrl_pkg;
   localparam int NUM_RESULTS = 45;
   localparam int IDX_W = 6;
   localparam int RAW_W = 12;
   localparam int NUM_SH = 6;
   localparam int CONV_TADS = 14;
   localparam int CLK_PERIOD_NS = 8;

   localparam logic [11:0] OFS_CTRL_ONE = 12'h000;
   localparam logic [11:0] OFS_CTRL_THREE = 12'h008;
   localparam logic [11:0] OFS_MODE = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_SCAN_LO = 12'h014;
   localparam logic [11:0] OFS_SCAN_HI = 12'h018;
   localparam logic [11:0] OFS_RESULT = 12'h100;
   localparam logic [11:0] OFS_RESULT_END = 12'h1B0;

   localparam logic [31:0] CTRL_ONE_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_ONE_WMASK = 32'h07C0_8B7F;
   localparam logic [31:0] MODE_WMASK = 32'h0000_3FFF;
   localparam logic [31:0] SCAN_HI_WMASK = 32'h0000_1FFF;
   localparam int DIV_LSB = 0;
   localparam int CLKSEL_LSB = 8;
   localparam int FRACTIONAL_FORMAT_BIT = 11;
   localparam int ENABLE_BIT = 15;
   localparam int TRIG_LSB = 22;
   localparam int SWREQ_BIT = 29;

   localparam logic [1:0] CLK_FAST_RC = 2'b11;
   localparam logic [1:0] CLK_REF_THREE = 2'b10;
   localparam logic [1:0] CLK_SYSTEM = 2'b01;
   localparam logic [4:0] TRIG_NONE = 5'b0_0000;
   localparam logic [4:0] TRIG_SOFTWARE = 5'b0_0001;
   localparam logic [4:0] TRIG_RESERVED = 5'b1_1111;
   localparam logic [5:0] IDX_TEMP = 6'h2C;
   localparam logic [5:0] IDX_LAST = 6'h2C;
   localparam logic [5:0] IDX_ONE = 6'h01;
   localparam logic [4:0] TAD_LAST = 5'h0D;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_WALK = 2'b01,
      SEQ_CONVERT = 2'b10,
      SEQ_STORE = 2'b11
   } seq_state_t;
endpackage

// ### common/result_if.sv
/*
 * carrier between the control block and its result memory.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface result_if;
   import adc_ctrl_pkg::*;
   logic ce;
   logic wrEn;
   logic [IDX_W-1:0] wrIdx;
   logic [31:0] wrData;
   logic [IDX_W-1:0] rdIdx;
   logic [31:0] rdData;
   modport ctrl (output ce, output wrEn, output wrIdx, output wrData, output rdIdx,
      input rdData);
   modport mem (input ce, input wrEn, input wrIdx, input wrData, input rdIdx,
      output rdData);
endinterface

// ### rtl/result_mem.sv
/*
 * 45-word result store, one write port, registered read port.
 * assumes the index stays below the word count.
 */
`timescale 1ns/10ps
module result_mem
   import adc_ctrl_pkg::*;
(
   input wire logic ref_clk, // register clock
   result_if.mem bus // write and read port
);
   logic [31:0] words [NUM_RESULTS];

   always_ff @(posedge ref_clk) begin
      if (bus.ce && bus.wrEn) begin
         words[bus.wrIdx] <= bus.wrData;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (bus.ce) begin
         bus.rdData <= words[bus.rdIdx];
      end
   end
endmodule

// ### rtl/adc_clock_trigger_results.sv
/*
 * converter control: clock select, conversion clock divider, scan trigger
 * select, software request, scan sequencer and result formatting.
 * assumes the analog core gives rawData valid at the end of each conversion
 * and the clock source ticks and trigger lines are synchronous to ref_clk.
 */
// Implementation choices: the address map and strobed register access.
`timescale 1ns/10ps
module adc_clock_trigger_results
   import adc_ctrl_pkg::*;
(
   input wire logic ref_clk, // register clock, 125 MHz
   input wire logic reset, // synchronous, active high
   input wire logic ce, // clock enable, freezes all state
   input wire logic [11:0] addr, // byte address
   input wire logic [31:0] wrData, // write data
   input wire logic wrStb, // write strobe
   input wire logic rdStb, // read strobe
   output logic [31:0] rdData, // read data, cycle after rdStb
   input wire logic fastRcTick, // internal fast rc tick
   input wire logic refClkThreeTick, // reference clock three tick
   input wire logic [31:0] trigLines, // trigger sources by code
   input wire logic [RAW_W-1:0] rawData, // converter raw output
   output logic tadTick, // conversion clock pulse
   output logic convActive, // conversion in progress
   output logic [IDX_W-1:0] convChannel, // input being converted
   output logic sharedSh // input uses shared sample hold
);
   result_if rif ();
   result_mem u_mem (
      .ref_clk(ref_clk),
      .bus(rif)
   );

   logic [31:0] ctrlOne_q;
   logic [13:0] mode_q;
   logic [31:0] scanLo_q;
   logic [12:0] scanHi_q;
   logic swReq_q;
   logic trigPrev_q;
   logic [7:0] divCnt_q;
   seq_state_t state_q;
   logic [IDX_W-1:0] idx_q;
   logic [4:0] tadCnt_q;
   logic done_q;
   logic [31:0] regRd_q;
   logic resSel_q;
   logic [31:0] resultWord;
   logic srcTick;
   logic trigLevel;
   logic trigFire;
   logic enable;
   logic [44:0] scanMask;
   logic isResult;

   // mode field for an input: dedicated holds first, then the shared one
   function automatic logic [1:0] modeOf(input logic [IDX_W-1:0] n, input logic [13:0] m);
      logic [2:0] sh;
      sh = (n < IDX_W'(NUM_SH)) ? n[2:0] : 3'(NUM_SH);
      modeOf = m[sh*2 +: 2];
   endfunction

   // raw code to result word by input mode and fraction setting
   function automatic logic [31:0] formatResult(input logic [RAW_W-1:0] raw,
      input logic [1:0] mode, input logic fractional_format);
      logic [RAW_W-1:0] code;
      code = mode[0] ? {~raw[RAW_W-1], raw[RAW_W-2:0]} : raw;
      if (fractional_format) begin
         formatResult = {code, 20'h0_0000};
      end else if (mode[0]) begin
         formatResult = {{(32-RAW_W){code[RAW_W-1]}}, code};
      end else begin
         formatResult = {{(32-RAW_W){1'b0}}, code};
      end
   endfunction

   assign enable = ctrlOne_q[ENABLE_BIT];
   assign scanMask = {scanHi_q, scanLo_q};
   assign isResult = (addr >= OFS_RESULT) && (addr <= OFS_RESULT_END);

   always_comb begin
      case (ctrlOne_q[CLKSEL_LSB +: 2])
         CLK_FAST_RC: srcTick = fastRcTick;
         CLK_REF_THREE: srcTick = refClkThreeTick;
         CLK_SYSTEM: srcTick = 1'b1;
         default: srcTick = 1'b0;
      endcase
   end

   assign tadTick = enable && srcTick && ((ctrlOne_q[DIV_LSB +: 7] == 7'h00)
      || (divCnt_q == {ctrlOne_q[DIV_LSB +: 7], 1'b0} - 8'h01));

   always_ff @(posedge ref_clk) begin
      if (reset || (ce && !enable)) begin
         divCnt_q <= 8'h00;
      end else if (ce && srcTick) begin
         divCnt_q <= tadTick ? 8'h00 : divCnt_q + 8'h01;
      end
   end

   always_comb begin
      case (ctrlOne_q[TRIG_LSB +: 5])
         TRIG_NONE, TRIG_RESERVED: trigLevel = 1'b0;
         TRIG_SOFTWARE: trigLevel = 1'b0;
         default: trigLevel = trigLines[ctrlOne_q[TRIG_LSB +: 5]];
      endcase
   end

   assign trigFire = (trigLevel && !trigPrev_q) || swReq_q;

   always_ff @(posedge ref_clk) begin
      if (reset || (ce && !enable)) begin
         trigPrev_q <= 1'b0;
      end else if (ce) begin
         trigPrev_q <= trigLevel;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrlOne_q <= CTRL_ONE_RESET;
         mode_q <= '0;
         scanLo_q <= '0;
         scanHi_q <= '0;
      end else if (ce && wrStb) begin
         case (addr)
            OFS_CTRL_ONE: ctrlOne_q <= wrData & CTRL_ONE_WMASK;
            OFS_MODE: mode_q <= wrData[13:0];
            OFS_SCAN_LO: scanLo_q <= wrData;
            OFS_SCAN_HI: scanHi_q <= wrData[12:0];
            default: ;
         endcase
      end
   end

   // request held until the sequencer takes it; dropped while disabled
   always_ff @(posedge ref_clk) begin
      if (reset || (ce && !enable)) begin
         swReq_q <= 1'b0;
      end else if (ce) begin
         if (wrStb && addr == OFS_CTRL_THREE && wrData[SWREQ_BIT]) begin
            swReq_q <= 1'b1;
         end else if (state_q == SEQ_IDLE) begin
            swReq_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || (ce && !enable)) begin
         state_q <= SEQ_IDLE;
         idx_q <= '0;
         tadCnt_q <= '0;
      end else if (ce) begin
         case (state_q)
            SEQ_IDLE: begin
               idx_q <= '0;
               if (trigFire) begin
                  state_q <= SEQ_WALK;
               end
            end
            SEQ_WALK: begin
               tadCnt_q <= '0;
               if (scanMask[idx_q]) begin
                  state_q <= SEQ_CONVERT;
               end else if (idx_q == IDX_LAST) begin
                  state_q <= SEQ_IDLE;
               end else begin
                  idx_q <= idx_q + IDX_ONE;
               end
            end
            SEQ_CONVERT: begin
               if (tadTick) begin
                  tadCnt_q <= tadCnt_q + 5'h01;
                  if (tadCnt_q == TAD_LAST) begin
                     state_q <= SEQ_STORE;
                  end
               end
            end
            SEQ_STORE: begin
               if (idx_q == IDX_LAST) begin
                  state_q <= SEQ_IDLE;
               end else begin
                  idx_q <= idx_q + IDX_ONE;
                  state_q <= SEQ_WALK;
               end
            end
            default: state_q <= SEQ_IDLE;
         endcase
      end
   end

   // scan complete flag, set wins over clear on status read
   always_ff @(posedge ref_clk) begin
      if (reset || (ce && !enable)) begin
         done_q <= 1'b0;
      end else if (ce) begin
         // a scan ends at the last index, stored or skipped
         if ((state_q == SEQ_STORE || (state_q == SEQ_WALK && !scanMask[idx_q]))
            && idx_q == IDX_LAST) begin
            done_q <= 1'b1;
         end else if (rdStb && addr == OFS_STATUS) begin
            done_q <= 1'b0;
         end
      end
   end

   assign convActive = (state_q == SEQ_CONVERT);
   assign convChannel = idx_q;
   assign sharedSh = (idx_q >= IDX_W'(NUM_SH)) || (idx_q == IDX_TEMP);

   assign resultWord = formatResult(rawData, modeOf(idx_q, mode_q), ctrlOne_q[FRACTIONAL_FORMAT_BIT]);

   assign rif.ce = ce;
   assign rif.wrEn = (state_q == SEQ_STORE);
   assign rif.wrIdx = idx_q;
   assign rif.wrData = resultWord;
   assign rif.rdIdx = IDX_W'((addr - OFS_RESULT) >> 2);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         regRd_q <= '0;
         resSel_q <= 1'b0;
      end else if (ce) begin
         resSel_q <= rdStb && isResult;
         if (rdStb) begin
            case (addr)
               OFS_CTRL_ONE: regRd_q <= ctrlOne_q;
               OFS_CTRL_THREE: regRd_q <= {2'b00, swReq_q, 29'h0000_0000};
               OFS_MODE: regRd_q <= {18'h0_0000, mode_q};
               OFS_STATUS: regRd_q <= {24'h00_0000, done_q, convActive, idx_q};
               OFS_SCAN_LO: regRd_q <= scanLo_q;
               OFS_SCAN_HI: regRd_q <= {19'h0_0000, scanHi_q};
               default: regRd_q <= '0;
            endcase
         end else begin
            regRd_q <= '0;
         end
      end
   end

   assign rdData = resSel_q ? rif.rdData : regRd_q;
endmodule

// ### test/adc_ctrl_properties.sv
/* port checker for the converter control block.
   assumes one clock domain and ce held high by the bench. */
`timescale 1ns/10ps
module adc_ctrl_properties
   import adc_ctrl_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic reset, // sync reset
   input wire logic ce, // clock enable
   input wire logic [11:0] addr, // address
   input wire logic [31:0] wrData, // write data
   input wire logic wrStb, // write strobe
   input wire logic rdStb, // read strobe
   input wire logic [31:0] rdData, // read data
   input wire logic tadTick, // conversion clock
   input wire logic convActive, // converting
   input wire logic [IDX_W-1:0] convChannel, // channel
   input wire logic sharedSh // shared hold
);
   logic [31:0] ctrlOne_q;
   logic [8:0] gap_q;
   logic [4:0] ticks_q;
   logic oneRead, sysDirect, enOn;
   assign oneRead = rdStb && addr == OFS_CTRL_ONE;
   assign enOn = ctrlOne_q[ENABLE_BIT];
   assign sysDirect = enOn && ctrlOne_q[9:8] == CLK_SYSTEM && ctrlOne_q[6:0] == 7'h00;
   // shadow of control_reg_one
   always_ff @(posedge ref_clk) begin
      if (reset) ctrlOne_q <= CTRL_ONE_RESET;
      else if (ce && wrStb && addr == OFS_CTRL_ONE) ctrlOne_q <= wrData & CTRL_ONE_WMASK;
   end
   // cycles since last tick, only valid inside a conversion
   always_ff @(posedge ref_clk) begin
      if (reset || !convActive || wrStb) gap_q <= 9'h000;
      else if (tadTick) gap_q <= 9'h001;
      else if (gap_q != 9'h000) gap_q <= gap_q + 9'h001;
   end
   always_ff @(posedge ref_clk) begin
      if (reset || !convActive) ticks_q <= 5'h00;
      else if (tadTick) ticks_q <= ticks_q + 5'h01;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   chk_shared_flag: assert property (sharedSh == (convChannel >= 6'h06))
      else $error("shared hold flag wrong");
   chk_channel_range: assert property (convChannel <= IDX_LAST)
      else $error("channel index out of range");
   chk_off_quiet: assert property (!enOn && !$past(enOn)
      |-> !convActive && !tadTick)
      else $error("activity while disabled");
   chk_ctrl_readback: assert property ($past(oneRead) |-> rdData == ctrlOne_q)
      else $error("control readback wrong");
   chk_no_source: assert property (ctrlOne_q[9:8] == 2'b00
      && $past(ctrlOne_q[9:8]) == 2'b00 |-> !tadTick)
      else $error("tick with no clock source");
   chk_pass_through: assert property (sysDirect && $past(sysDirect)
      && convActive |-> tadTick)
      else $error("undivided clock missed a tick");
   chk_div_period: assert property (tadTick && gap_q != 9'h000
      && ctrlOne_q[9:8] == CLK_SYSTEM && ctrlOne_q[6:0] != 7'h00
      |-> gap_q == {1'b0, ctrlOne_q[6:0], 1'b0})
      else $error("divided tick period wrong");
   chk_conv_length: assert property ($fell(convActive) && enOn |-> ticks_q == 5'h0E)
      else $error("conversion length wrong");
   cover property ($fell(convActive));
   cover property (convActive && convChannel == IDX_TEMP);
   cover property (tadTick && gap_q == 9'h0FE);
endmodule
bind adc_clock_trigger_results adc_ctrl_properties i_props (.ref_clk(ref_clk), .reset(reset),
   .ce(ce), .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
   .tadTick(tadTick), .convActive(convActive), .convChannel(convChannel), .sharedSh(sharedSh));

// ### test/tb_top.sv
/* self-checking bench for the converter control block.
   assumes the bound port checker; raw data follows the channel. */
`timescale 1ns/10ps
module tb_top
   import adc_ctrl_pkg::*;
();
   localparam logic [31:0] BASE = 32'h0040_8100; // enabled, system clock, software trigger
   logic ref_clk = 1'b0, reset = 1'b1, ce = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
   logic fastRcTick = 1'b0, refClkThreeTick = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wrData = 32'h0000_0000, trigLines = 32'h0000_0000, rdData, rv;
   logic [RAW_W-1:0] rawData = 12'h000;
   logic tadTick, convActive, sharedSh;
   logic [IDX_W-1:0] convChannel;
   int failures = 0, total_checks = 0, cycles = 0, len;
   adc_clock_trigger_results i_dut (.ref_clk(ref_clk), .reset(reset), .ce(ce), .addr(addr),
      .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .fastRcTick(fastRcTick),
      .refClkThreeTick(refClkThreeTick), .trigLines(trigLines), .rawData(rawData),
      .tadTick(tadTick), .convActive(convActive), .convChannel(convChannel), .sharedSh(sharedSh));
   always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   // source ticks every 3 and 5 cycles, timeout
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      fastRcTick <= cycles % 3 == 0;
      refClkThreeTick <= cycles % 5 == 0;
      rawData <= {6'h2A, convChannel};
      if (cycles == 40000) begin
         failures++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      addr <= a;
      wrData <= d;
      wrStb <= 1'b1;
      @(posedge ref_clk);
      wrStb <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1 d = rdData;
      @(posedge ref_clk);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      rd(a, rv);
      check(rv, e);
   endtask
   task automatic fire(input int c);
      trigLines <= 32'h0000_0001 << c;
      @(posedge ref_clk);
      trigLines <= 32'h0000_0000;
   endtask
   task automatic quiet();
      int hits;
      hits = 0;
      repeat (30) begin
         #1 hits += int'(convActive !== 1'b0);
         @(posedge ref_clk);
      end
      check(32'(hits), 32'h0000_0000);
   endtask
   // waits for a scan start, measures the first conversion, polls done
   task automatic run(output int len);
      int n;
      n = 0;
      len = 0;
      #1;
      while (convActive !== 1'b1 && n < 400) begin
         @(posedge ref_clk);
         #1 n++;
      end
      while (convActive === 1'b1 && len < 4000) begin
         @(posedge ref_clk);
         #1 len++;
      end
      check(32'(n < 400), 32'h0000_0001);
      rv = 32'h0000_0000;
      for (n = 0; n < 4000 && rv[7] !== 1'b1; n++) begin
         @(posedge ref_clk);
         rd(OFS_STATUS, rv);
      end
      check(32'(rv[7]), 32'h0000_0001);
      check(32'(rv[6]), 32'h0000_0000);
   endtask
   task automatic go(output int len);
      wr(OFS_CTRL_THREE, 32'h2000_0000);
      run(len);
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      rdc(OFS_CTRL_ONE, CTRL_ONE_RESET);
      wr(OFS_CTRL_ONE, 32'hFFFF_FFFF);
      rdc(OFS_CTRL_ONE, CTRL_ONE_WMASK);
      fire(31);
      quiet();
      $display("test reserved trigger done");
      wr(OFS_MODE, 32'h0000_0000);
      wr(OFS_SCAN_LO, 32'hFFFF_FFFF);
      wr(OFS_SCAN_HI, 32'hFFFF_FFFF);
      wr(OFS_CTRL_ONE, BASE);
      go(len);
      for (int n = 0; n <= 44; n++) begin
         rdc(OFS_RESULT + 12'(4 * n), {20'h0_0000, 6'h2A, 6'(n)});
      end
      wr(OFS_RESULT, 32'hFFFF_FFFF);
      rdc(OFS_RESULT, 32'h0000_0A80);
      $display("test full scan done");
      wr(OFS_SCAN_HI, 32'h0000_0000);
      wr(OFS_SCAN_LO, 32'h0000_0001);
      for (int m = 0; m < 4; m++) begin
         wr(OFS_MODE, 32'(m));
         wr(OFS_CTRL_ONE, BASE | 32'h0000_0800);
         go(len);
         rdc(OFS_RESULT, m[0] ? 32'h2800_0000 : 32'hA800_0000);
         wr(OFS_CTRL_ONE, BASE);
         go(len);
         rdc(OFS_RESULT, m[0] ? 32'h0000_0280 : 32'h0000_0A80);
      end
      $display("test input modes done");
      for (int k = 1; k <= 127; k += 126) begin
         wr(OFS_CTRL_ONE, BASE | 32'(k));
         go(len);
         check(32'(len >= 26 * k && len <= 28 * k + 2), 32'h0000_0001);
      end
      $display("test divider done");
      for (int s = 2; s <= 3; s++) begin
         wr(OFS_CTRL_ONE, {BASE[31:10], 2'(s), BASE[7:0]});
         go(len);
         check(32'(len >= 13 * (9 - 2 * s) && len <= 14 * (9 - 2 * s) + 2),
            32'h0000_0001);
      end
      $display("test clock sources done");
      for (int c = 0; c <= 30; c++) begin
         wr(OFS_CTRL_ONE, {BASE[31:27], 5'(c), BASE[21:0]});
         fire(c);
         if (c < 2) quiet(); else run(len);
      end
      $display("test trigger lines done");
      wr(OFS_CTRL_ONE, {BASE[31:10], 2'b00, BASE[7:0]});
      wr(OFS_CTRL_THREE, 32'h2000_0000);
      repeat (20) @(posedge ref_clk);
      #1 check(32'(convActive), 32'h0000_0001);
      @(posedge ref_clk);
      wr(OFS_CTRL_ONE, 32'h0000_0000);
      rdc(OFS_STATUS, 32'h0000_0000);
      rdc(OFS_CTRL_ONE, 32'h0000_0000);
      $display("test disable done");
      summarize();
   end
endmodule
